/* verilog/bcp_control.sv */
/*
  Cycle level switch control and protection sequencer for two buck channels.
  Assumes comparator inputs already synchronous to the 20 MHz clock and a
  serial interface front end that issues one-cycle register strobes.
*/
// Contract
// - Lock to sync clock 200 to 1600 kHz.
// - Sync cycle starts on clock falling edge.
// - Resistor mode until external clock seen.
// - First high level enters sync, releases pin.
// - Soft-start below reference sets the reference.
// - One voltage code register per channel.
// - Apply bit swaps external for internal divider.
// - Second channel starts half a period later.
// - Overvoltage holds high side off.
// - Boot undervoltage forces recharge via low side.
// - Peak current ends the high side pulse.
// - Source limit at cycle end skips pulse.
// - Sink limit turns both off till next cycle.
// - 512 overload cycles shut down, 16384 hiccup.
// - Overtemperature stops; restart 16384 cycles after clear.
`default_nettype none
`include "bcp_regs.svh"

module bcp_control (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       freqSetIn,
  input  wire logic [7:0] resPeriod,
  input  wire logic [1:0] ssBelowRef,
  input  wire logic [1:0] ovpFlag,
  input  wire logic [1:0] bootUvFlag,
  input  wire logic [1:0] peakCurFlag,
  input  wire logic [1:0] lsSourceLimit,
  input  wire logic [1:0] lsSinkLimit,
  input  wire logic [1:0] overloadFlag,
  input  wire logic       thermHot,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic      [7:0] voltageCode1,
  output logic      [7:0] voltageCode2,
  output logic      [1:0] useInternalDivider,
  output logic      [1:0] refSoftStart,
  output logic      [1:0] hsOn,
  output logic      [1:0] lsOn,
  output logic      [1:0] hiccupActive,
  output logic            syncMode,
  output logic            syncLocked,
  output logic            freqSetRelease,
  output logic            thermStop
);
  localparam logic [7:0]  SyncMinCyc = 8'(`BCP_SYNC_MIN_CYC);
  localparam logic [7:0]  SyncMaxCyc = 8'(`BCP_SYNC_MAX_CYC);
  localparam logic [7:0]  FallbackCyc = 8'(`BCP_FALLBACK_CYC);
  localparam logic [13:0] HiccupLast = 14'(`BCP_HICCUP_CYCLES - 1);
  localparam logic [9:0]  OverloadLast = 10'(`BCP_OVERLOAD_CYCLES - 1);

  // ============================================================
  // Switching clock: resistor oscillator or external sync
  bcp_pkg::bcp_freq_e freqMode;
  bcp_pkg::bcp_freq_e next_freqMode;
  logic [7:0] phaseCnt;
  logic [7:0] periodLen;
  logic       fsPrev;
  logic       locked;
  logic [7:0] next_phaseCnt;
  logic [7:0] next_periodLen;
  logic       next_locked;
  logic       fsFall;
  logic       start1;
  logic       start2;
  logic [1:0] cycStart;

  always_comb begin
    next_freqMode = freqMode;
    start1 = 1'b0;
    fsFall = fsPrev && !freqSetIn;
    case (freqMode)
      bcp_pkg::FREQ_RESISTOR: begin
        if (freqSetIn) begin
          next_freqMode = bcp_pkg::FREQ_SYNC;
        end else if (phaseCnt + 8'h01 >= resPeriod) begin
          start1 = 1'b1;
        end
      end
      bcp_pkg::FREQ_SYNC: begin
        if (fsFall) begin
          start1 = 1'b1;
        end else if (phaseCnt == FallbackCyc - 8'h01) begin
          // Clock lost: run one slow cycle before the resistor takes over.
          start1 = 1'b1;
          next_freqMode = bcp_pkg::FREQ_FALLBACK;
        end
      end
      bcp_pkg::FREQ_FALLBACK: begin
        if (freqSetIn) begin
          next_freqMode = bcp_pkg::FREQ_SYNC;
        end else if (phaseCnt == FallbackCyc - 8'h01) begin
          start1 = 1'b1;
          next_freqMode = bcp_pkg::FREQ_RESISTOR;
        end
      end
      default: next_freqMode = bcp_pkg::FREQ_RESISTOR;
    endcase
    next_phaseCnt = phaseCnt;
    next_periodLen = periodLen;
    next_locked = locked;
    if (start1) begin
      next_phaseCnt = 8'h00;
      next_periodLen = phaseCnt + 8'h01;
      next_locked = (freqMode == bcp_pkg::FREQ_SYNC) && fsFall
                    && phaseCnt + 8'h01 >= SyncMinCyc
                    && phaseCnt + 8'h01 <= SyncMaxCyc;
    end else if (phaseCnt != 8'hFF) begin
      next_phaseCnt = phaseCnt + 8'h01;
    end
    if (next_freqMode != bcp_pkg::FREQ_SYNC) begin
      next_locked = 1'b0;
    end
    // The second channel runs off the period just measured.
    // The count reads zero one cycle after a start, hence one less than half.
    start2 = !start1 && phaseCnt == {1'b0, periodLen[7:1]} - 8'h01;
    cycStart = {start2, start1};
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      freqMode <= bcp_pkg::FREQ_RESISTOR;
      phaseCnt <= 8'h00;
      periodLen <= FallbackCyc;
      fsPrev <= 1'b0;
      locked <= 1'b0;
    end else begin
      freqMode <= next_freqMode;
      phaseCnt <= next_phaseCnt;
      periodLen <= next_periodLen;
      fsPrev <= freqSetIn;
      locked <= next_locked;
    end
  end

  assign syncMode = freqMode == bcp_pkg::FREQ_SYNC;
  assign syncLocked = locked;
  assign freqSetRelease = freqMode != bcp_pkg::FREQ_RESISTOR;

  // ============================================================
  // Thermal shutdown and restart timer
  bcp_pkg::bcp_therm_e thermState;
  bcp_pkg::bcp_therm_e next_thermState;
  logic [13:0] thermCnt;
  logic [13:0] next_thermCnt;

  always_comb begin
    next_thermState = thermState;
    next_thermCnt = thermCnt;
    case (thermState)
      bcp_pkg::THERM_OK: begin
        if (thermHot) begin
          next_thermState = bcp_pkg::THERM_HOT;
        end
      end
      bcp_pkg::THERM_HOT: begin
        if (!thermHot) begin
          next_thermState = bcp_pkg::THERM_WAIT;
          next_thermCnt = 14'h0000;
        end
      end
      bcp_pkg::THERM_WAIT: begin
        if (thermHot) begin
          next_thermState = bcp_pkg::THERM_HOT;
        end else if (start1 && thermCnt == HiccupLast) begin
          next_thermState = bcp_pkg::THERM_OK;
        end else if (start1) begin
          next_thermCnt = thermCnt + 14'h0001;
        end
      end
      default: next_thermState = bcp_pkg::THERM_HOT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      thermState <= bcp_pkg::THERM_OK;
      thermCnt <= 14'h0000;
    end else begin
      thermState <= next_thermState;
      thermCnt <= next_thermCnt;
    end
  end

  assign thermStop = thermState != bcp_pkg::THERM_OK;

  // ============================================================
  // Soft-start reference select
  logic [1:0] ssRef;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ssRef <= 2'h3;
    end else begin
      ssRef <= ssBelowRef;
    end
  end

  assign refSoftStart = ssRef;

  // ============================================================
  // Per-channel switch control and overload hiccup
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    bcp_pkg::bcp_prot_e protState;
    bcp_pkg::bcp_prot_e next_protState;
    logic [9:0]  olCnt;
    logic [13:0] hicCnt;
    logic        hs;
    logic        ls;
    logic [9:0]  next_olCnt;
    logic [13:0] next_hicCnt;
    logic        next_hs;
    logic        next_ls;
    logic        run;

    always_comb begin
      next_protState = protState;
      next_olCnt = olCnt;
      next_hicCnt = hicCnt;
      run = protState == bcp_pkg::PROT_RUN && !thermStop;
      case (protState)
        bcp_pkg::PROT_RUN: begin
          if (!overloadFlag[ch]) begin
            next_olCnt = 10'h000;
          end else if (cycStart[ch] && olCnt == OverloadLast) begin
            next_protState = bcp_pkg::PROT_HICCUP;
            next_hicCnt = 14'h0000;
          end else if (cycStart[ch]) begin
            next_olCnt = olCnt + 10'h001;
          end
        end
        bcp_pkg::PROT_HICCUP: begin
          if (cycStart[ch] && hicCnt == HiccupLast) begin
            next_protState = bcp_pkg::PROT_RUN;
            next_olCnt = 10'h000;
          end else if (cycStart[ch]) begin
            next_hicCnt = hicCnt + 14'h0001;
          end
        end
        default: next_protState = bcp_pkg::PROT_HICCUP;
      endcase
      next_hs = hs;
      next_ls = ls;
      if (!run) begin
        next_hs = 1'b0;
        next_ls = 1'b0;
      end else if (cycStart[ch]) begin
        // A pulse that never tripped simply continues: full duty is allowed.
        if (lsSourceLimit[ch] || bootUvFlag[ch] || ovpFlag[ch]) begin
          next_hs = 1'b0;
          next_ls = 1'b1;
        end else begin
          next_hs = 1'b1;
          next_ls = 1'b0;
        end
      end else if (hs && (peakCurFlag[ch] || bootUvFlag[ch] || ovpFlag[ch])) begin
        next_hs = 1'b0;
        next_ls = 1'b1;
      end else if (ls && lsSinkLimit[ch]) begin
        next_ls = 1'b0;
      end
    end

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        protState <= bcp_pkg::PROT_RUN;
        olCnt <= 10'h000;
        hicCnt <= 14'h0000;
        hs <= 1'b0;
        ls <= 1'b0;
      end else begin
        protState <= next_protState;
        olCnt <= next_olCnt;
        hicCnt <= next_hicCnt;
        hs <= next_hs;
        ls <= next_ls;
      end
    end

    assign hsOn[ch] = hs;
    assign lsOn[ch] = ls;
    assign hiccupActive[ch] = protState == bcp_pkg::PROT_HICCUP;

    AST_OVP_HS_OFF: assert property (ovpFlag[ch] |=> !hs)
      else $error("High side conducted during overvoltage.");
    AST_PEAK_ENDS_PULSE: assert property (hs && peakCurFlag[ch] && run && !cycStart[ch]
      |=> !hs && ls)
      else $error("Peak current did not end the pulse.");
    AST_BOOT_RECHARGE: assert property (bootUvFlag[ch] && run |=> !hs && ls)
      else $error("Boot undervoltage did not force recharge.");
    AST_SOURCE_SKIP: assert property (cycStart[ch] && lsSourceLimit[ch] && run
      |=> !hs && ls)
      else $error("Pulse not skipped on source limit.");
    AST_SINK_BOTH_OFF: assert property (ls && lsSinkLimit[ch] && !cycStart[ch]
      |=> !ls && !hs)
      else $error("Sink limit did not open both switches.");
    AST_OL_CLEAR: assert property (!overloadFlag[ch] && protState == bcp_pkg::PROT_RUN
      |=> olCnt == 10'h000)
      else $error("Overload counter kept its count.");
    AST_HICCUP_OFF: assert property (hiccupActive[ch] |=> !hs && !ls)
      else $error("Switching during hiccup.");
    COV_HICCUP: cover property ($rose(hiccupActive[ch]));
  end

  AST_SYNC_ENTRY: assert property (freqMode == bcp_pkg::FREQ_RESISTOR && freqSetIn
    |=> syncMode && freqSetRelease)
    else $error("Sync mode not entered on a high pin.");
  AST_RES_HOLD: assert property (freqMode == bcp_pkg::FREQ_RESISTOR && !freqSetIn
    |=> !syncMode)
    else $error("Left resistor mode without a clock.");
  AST_SYNC_FALL_START: assert property (syncMode && fsPrev && !freqSetIn |-> start1)
    else $error("Falling edge did not start a cycle.");
  AST_HALF_PERIOD: assert property (start1 |-> ##[1:200] start2)
    else $error("Second channel did not follow the first.");
  AST_THERM_STOP: assert property (thermHot |=> ##1 !hsOn[0] && !hsOn[1])
    else $error("Switching while hot.");
  COV_SYNC_LOCK: cover property ($rose(syncLocked));
  COV_THERM_RESTART: cover property ($fell(thermStop));

  // ============================================================
  // Register file
  bcp_vsel_regs uRegs (
    .clock              (clock),
    .rst_b              (rst_b),
    .regWrite           (regWrite),
    .regRead            (regRead),
    .regAddr            (regAddr),
    .regWdata           (regWdata),
    .statusBits         ({hiccupActive, thermStop, syncLocked, syncMode}),
    .regRdata           (regRdata),
    .voltageCode1       (voltageCode1),
    .voltageCode2       (voltageCode2),
    .useInternalDivider (useInternalDivider)
  );
endmodule

`default_nettype wire

/* verilog/bcp_regs.svh */
/*
  Named offsets, field positions, reset values and timing counts of the
  buck cycle protection control block.
  Assumes a 20 MHz block clock; included by bare name.
*/
`ifndef BCP_REGS_SVH
`define BCP_REGS_SVH

// ============================================================
// Register map
`define BCP_OFS_VSEL1 8'h00
`define BCP_OFS_VSEL2 8'h01
`define BCP_OFS_CTRL 8'h02
`define BCP_VSEL_RST 8'h00
`define BCP_RDATA_RST 8'h00
`define BCP_CTRL_APPLY 0
`define BCP_CTRL_SYNC 1
`define BCP_CTRL_LOCK 2
`define BCP_CTRL_THERM 3
`define BCP_CTRL_HIC_LO 4

// ============================================================
// Timing
`define BCP_CLK_MHZ 20
`define BCP_SYNC_MIN_NS 625
`define BCP_SYNC_MAX_NS 5000
`define BCP_FALLBACK_NS 10000
`define BCP_NS2CYC_UP(ns) ((((ns) * `BCP_CLK_MHZ) + 999) / 1000)
`define BCP_NS2CYC_DN(ns) (((ns) * `BCP_CLK_MHZ) / 1000)
`define BCP_SYNC_MIN_CYC `BCP_NS2CYC_UP(`BCP_SYNC_MIN_NS)
`define BCP_SYNC_MAX_CYC `BCP_NS2CYC_DN(`BCP_SYNC_MAX_NS)
`define BCP_FALLBACK_CYC `BCP_NS2CYC_DN(`BCP_FALLBACK_NS)
`define BCP_OVERLOAD_CYCLES 512
`define BCP_HICCUP_CYCLES 16384

`endif

/* verilog/bcp_pkg.sv */
/*
  Types shared by the buck cycle protection control block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package bcp_pkg;
  typedef enum logic [1:0] {FREQ_RESISTOR, FREQ_SYNC, FREQ_FALLBACK} bcp_freq_e;
  typedef enum logic {PROT_RUN, PROT_HICCUP} bcp_prot_e;
  typedef enum logic [1:0] {THERM_OK, THERM_HOT, THERM_WAIT} bcp_therm_e;
endpackage

`default_nettype wire

/* verilog/bcp_vsel_regs.sv */
/*
  Voltage code registers of both channels and the apply control register.
  Assumes single-cycle write and read strobes from the serial interface logic.
*/
`default_nettype none
`include "bcp_regs.svh"

module bcp_vsel_regs (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic [4:0] statusBits,
  output logic      [7:0] regRdata,
  output logic      [7:0] voltageCode1,
  output logic      [7:0] voltageCode2,
  output logic      [1:0] useInternalDivider
);
  logic [7:0] vsel1;
  logic [7:0] vsel2;
  logic [1:0] codeChosen;
  logic       apply;
  logic [1:0] internalDiv;
  logic [7:0] rdata;
  logic [7:0] next_vsel1;
  logic [7:0] next_vsel2;
  logic [1:0] next_codeChosen;
  logic       next_apply;
  logic [1:0] next_internalDiv;
  logic [7:0] next_rdata;

  // ============================================================
  // Write and read decode
  always_comb begin
    next_vsel1 = vsel1;
    next_vsel2 = vsel2;
    next_codeChosen = codeChosen;
    next_apply = apply;
    next_rdata = rdata;
    if (regWrite && regAddr == `BCP_OFS_VSEL1) begin
      next_vsel1 = regWdata;
      next_codeChosen[0] = 1'b1;
    end
    if (regWrite && regAddr == `BCP_OFS_VSEL2) begin
      next_vsel2 = regWdata;
      next_codeChosen[1] = 1'b1;
    end
    if (regWrite && regAddr == `BCP_OFS_CTRL && regWdata[`BCP_CTRL_APPLY]) begin
      next_apply = 1'b1;
    end
    // Once switched, a channel stays on the internal divider until reset.
    next_internalDiv = internalDiv | ({2{apply}} & codeChosen);
    if (regRead) begin
      case (regAddr)
        `BCP_OFS_VSEL1: next_rdata = vsel1;
        `BCP_OFS_VSEL2: next_rdata = vsel2;
        `BCP_OFS_CTRL:  next_rdata = {2'h0, statusBits, apply};
        default:        next_rdata = `BCP_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vsel1 <= `BCP_VSEL_RST;
      vsel2 <= `BCP_VSEL_RST;
      codeChosen <= 2'h0;
      apply <= 1'b0;
      internalDiv <= 2'h0;
      rdata <= `BCP_RDATA_RST;
    end else begin
      vsel1 <= next_vsel1;
      vsel2 <= next_vsel2;
      codeChosen <= next_codeChosen;
      apply <= next_apply;
      internalDiv <= next_internalDiv;
      rdata <= next_rdata;
    end
  end

  assign regRdata = rdata;
  assign voltageCode1 = vsel1;
  assign voltageCode2 = vsel2;
  assign useInternalDivider = internalDiv;

  AST_APPLY_SWITCHES: assert property (@(posedge clock) disable iff (!rst_b)
    apply && codeChosen[0] |=> internalDiv[0])
    else $error("Channel 1 did not move to the internal divider.");
  COV_APPLY: cover property (@(posedge clock) disable iff (!rst_b) $rose(internalDiv[1]));
endmodule

`default_nettype wire

/* dv/bcp_stage_model.sv */
/*
  Behavioural power stage: peak current comparators and an external sync clock.
  Assumes the registered switch commands of the control block as its inputs.
*/
`default_nettype none

module bcp_stage_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       syncEn,
  input  wire logic       peakEn,
  input  wire logic [1:0] hsOn,
  output logic            freqSetIn,
  output logic      [1:0] peakCurFlag
);
  timeunit 1ns;
  timeprecision 1ns;

  // ============================================================
  // Sync clock of 20 cycles, 1 MHz, inside the lock range.
  localparam int SyncHalf = 10;
  localparam int PeakDelay = 5;

  logic [7:0] onCnt [2];
  logic [7:0] syncCnt;
  logic       syncRun;

  // Once applied the clock is never removed, so fallback is never entered.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      onCnt[0] <= 8'h00;
      onCnt[1] <= 8'h00;
      syncCnt <= 8'h00;
      syncRun <= 1'b0;
      freqSetIn <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        onCnt[i] <= hsOn[i] ? onCnt[i] + 8'h01 : 8'h00;
      end
      syncRun <= syncRun | syncEn;
      if (syncRun) begin
        syncCnt <= (syncCnt == 8'(SyncHalf - 1)) ? 8'h00 : syncCnt + 8'h01;
        if (syncCnt == 8'(SyncHalf - 1)) begin
          freqSetIn <= ~freqSetIn;
        end
      end
    end
  end

  // Switch current reaches the reference a fixed time into each pulse.
  assign peakCurFlag[0] = peakEn && (onCnt[0] >= 8'(PeakDelay));
  assign peakCurFlag[1] = peakEn && (onCnt[1] >= 8'(PeakDelay));
endmodule

`default_nettype wire

/* dv/buck_cycle_protection_control_test.sv */
/*
  Self-checking bench of the buck cycle protection control block.
  Assumes the stage model drives the peak flags and the frequency-set pin.
*/
`default_nettype none

module buck_cycle_protection_control_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PeakDelay = 5;
  localparam int ResPer = 20;

  logic clock, rst_b, freqSetIn, thermHot, regWrite, regRead;
  logic syncEn, peakEn, syncMode, syncLocked, freqSetRelease, thermStop;
  logic [7:0] resPeriod, regAddr, regWdata, regRdata, voltageCode1, voltageCode2, d;
  logic [1:0] ssBelowRef, ovpFlag, bootUvFlag, peakCurFlag, lsSourceLimit;
  logic [1:0] lsSinkLimit, overloadFlag, useInternalDivider, refSoftStart;
  logic [1:0] hsOn, lsOn, hiccupActive;
  int n_errors, n_tests, n;

  bcp_control dut (
    .clock(clock), .rst_b(rst_b), .freqSetIn(freqSetIn), .resPeriod(resPeriod),
    .ssBelowRef(ssBelowRef), .ovpFlag(ovpFlag), .bootUvFlag(bootUvFlag),
    .peakCurFlag(peakCurFlag), .lsSourceLimit(lsSourceLimit),
    .lsSinkLimit(lsSinkLimit), .overloadFlag(overloadFlag), .thermHot(thermHot),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .voltageCode1(voltageCode1), .voltageCode2(voltageCode2),
    .useInternalDivider(useInternalDivider), .refSoftStart(refSoftStart),
    .hsOn(hsOn), .lsOn(lsOn), .hiccupActive(hiccupActive), .syncMode(syncMode),
    .syncLocked(syncLocked), .freqSetRelease(freqSetRelease), .thermStop(thermStop)
  );

  bcp_stage_model stage (
    .clock(clock), .rst_b(rst_b), .syncEn(syncEn), .peakEn(peakEn),
    .hsOn(hsOn), .freqSetIn(freqSetIn), .peakCurFlag(peakCurFlag)
  );

  // ============================================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Settled outputs are sampled at the falling edge only.
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    tick(1);
    v = regRdata;
  endtask

  // Counts falling edges until the high-side command of a channel next rises.
  task automatic wait_rise(input int ch, input int maxc, output int c);
    c = 0;
    while (hsOn[ch] === 1'b1 && c < maxc) begin
      @(negedge clock);
      c++;
    end
    while (hsOn[ch] !== 1'b1 && c < maxc) begin
      @(negedge clock);
      c++;
    end
  endtask

  task automatic count_hs(input int k, output int c);
    c = 0;
    repeat (k) begin
      @(negedge clock);
      if (hsOn[0] === 1'b1) c++;
    end
  endtask

  task automatic wait_clear(input int sel, output int c);
    c = 0;
    while ((sel ? thermStop : hiccupActive[0]) !== 1'b0 && c < 33000) begin
      @(negedge clock);
      c++;
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic test_regs();
    rd(8'h00, d);
    check("vsel1 reset", d, 8'h00);
    rd(8'h01, d);
    check("vsel2 reset", d, 8'h00);
    wr(8'h00, 8'h2A);
    tick(3);
    check("divider before apply", 8'(useInternalDivider), 8'h00);
    wr(8'h02, 8'h01);
    tick(3);
    check("divider after apply", 8'(useInternalDivider), 8'h01);
    wr(8'h01, 8'h55);
    wr(8'h05, 8'hFF);
    rd(8'h00, d);
    check("vsel1", d, 8'h2A);
    check("code1 out", voltageCode1, 8'h2A);
    rd(8'h01, d);
    check("vsel2", d, 8'h55);
    check("code2 out", voltageCode2, 8'h55);
    check("divider both", 8'(useInternalDivider), 8'h03);
    rd(8'h05, d);
    check("unmapped", d, 8'h00);
    rd(8'h02, d);
    check("status", d, 8'h01);
    $display("test regs done");
  endtask

  task automatic test_soft();
    @(posedge clock);
    ssBelowRef <= 2'b01;
    tick(3);
    check("ref ss", 8'(refSoftStart), 8'h01);
    @(posedge clock);
    ssBelowRef <= 2'b00;
    $display("test soft done");
  endtask

  task automatic test_cycle();
    wait_rise(0, 60, n);
    n = 0;
    while (hsOn[0] === 1'b1 && n < 60) begin
      n++;
      @(negedge clock);
    end
    check("hs width", 8'(n), 8'(PeakDelay + 1));
    check("ls after peak", 8'(lsOn[0]), 8'h01);
    wait_rise(0, 60, n);
    check("rest of period", 8'(n), 8'(ResPer - PeakDelay - 1));
    wait_rise(1, 60, n);
    check("phase", 8'(n), 8'(ResPer / 2));
    $display("test cycle done");
  endtask

  task automatic test_guards();
    @(posedge clock);
    ovpFlag <= 2'b01;
    tick(2);
    count_hs(45, n);
    check("ovp hs", 8'(n), 8'h00);
    check("ovp ls", 8'(lsOn[0]), 8'h01);
    @(posedge clock);
    ovpFlag <= 2'b00;
    wait_rise(0, 60, n);
    check("ovp resume", 8'(n < ResPer + 4), 8'h01);
    @(posedge clock);
    peakEn <= 1'b0;
    tick(25);
    count_hs(45, n);
    check("full duty", 8'(n), 8'd45);
    @(posedge clock);
    bootUvFlag <= 2'b01;
    tick(2);
    check("boot recharge", {6'b0, hsOn[0], lsOn[0]}, 8'h01);
    @(posedge clock);
    bootUvFlag <= 2'b00;
    peakEn <= 1'b1;
    lsSourceLimit <= 2'b01;
    tick(ResPer);
    count_hs(45, n);
    check("source skip", 8'(n), 8'h00);
    check("source ls", 8'(lsOn[0]), 8'h01);
    @(posedge clock);
    lsSourceLimit <= 2'b00;
    wait_rise(0, 60, n);
    check("source resume", 8'(n < ResPer + 4), 8'h01);
    $display("test guards done");
  endtask

  task automatic test_sink();
    wait_rise(0, 60, n);
    tick(PeakDelay + 2);
    @(posedge clock);
    lsSinkLimit <= 2'b01;
    tick(2);
    check("sink both off", 8'({hsOn[0], lsOn[0]}), 8'h00);
    @(posedge clock);
    lsSinkLimit <= 2'b00;
    tick(2);
    check("sink held off", 8'(lsOn[0]), 8'h00);
    wait_rise(0, 60, n);
    check("sink next start", 8'(n < ResPer), 8'h01);
    $display("test sink done");
  endtask

  // With two-cycle periods each count of starts is twice as many clocks.
  task automatic test_overload();
    @(posedge clock);
    resPeriod <= 8'h02;
    overloadFlag <= 2'b01;
    tick(600);
    @(posedge clock);
    overloadFlag <= 2'b00;
    tick(4);
    @(posedge clock);
    overloadFlag <= 2'b01;
    n = 0;
    while (hiccupActive[0] !== 1'b1 && n < 1200) begin
      @(negedge clock);
      n++;
    end
    check("overload restart", 8'(n > 1010), 8'h01);
    check("overload trip", 8'(n < 1035), 8'h01);
    // The switches open one edge after the hiccup state is entered.
    tick(1);
    check("hiccup off", 8'({hsOn[0], lsOn[0]}), 8'h00);
    @(posedge clock);
    overloadFlag <= 2'b00;
    wait_clear(0, n);
    check("hiccup span", 8'(n > 32755 && n < 32785), 8'h01);
    $display("test overload done");
  endtask

  task automatic test_therm();
    @(posedge clock);
    thermHot <= 1'b1;
    tick(2);
    check("therm stop", 8'(thermStop), 8'h01);
    check("therm off", 8'(hsOn), 8'h00);
    tick(20);
    @(posedge clock);
    thermHot <= 1'b0;
    wait_clear(1, n);
    check("therm span", 8'(n > 32755 && n < 32785), 8'h01);
    $display("test therm done");
  endtask

  task automatic test_sync();
    @(posedge clock);
    resPeriod <= 8'd30;
    tick(70);
    check("resistor mode", 8'(syncMode), 8'h00);
    wait_rise(0, 80, n);
    wait_rise(0, 80, n);
    check("resistor period", 8'(n), 8'd30);
    @(posedge clock);
    syncEn <= 1'b1;
    tick(14);
    check("sync mode", 8'({syncMode, freqSetRelease}), 8'h03);
    tick(100);
    check("locked", 8'(syncLocked), 8'h01);
    wait_rise(0, 80, n);
    wait_rise(0, 80, n);
    check("sync period", 8'(n), 8'd20);
    $display("test sync done");
  endtask

  // ============================================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    #4_500_000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    {regWrite, regRead, thermHot, syncEn} = 4'h0;
    peakEn = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    resPeriod = 8'(ResPer);
    {ssBelowRef, ovpFlag, bootUvFlag} = 6'h00;
    {lsSourceLimit, lsSinkLimit, overloadFlag} = 6'h00;
    // The reference select is only at its reset value while reset is held.
    repeat (11) @(posedge clock);
    tick(0);
    check("ref reset", 8'(refSoftStart), 8'h03);
    @(posedge clock);
    rst_b <= 1'b1;
    tick(1);
    test_soft();
    test_regs();
    test_cycle();
    test_guards();
    test_sink();
    test_overload();
    test_therm();
    test_sync();
    report_and_stop();
  end
endmodule

`default_nettype wire
